//--- core/sadc_map.vh
// register offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SADC_MAP_VH
`define SADC_MAP_VH
`define SADC_OFF_CTRL       12'h000
`define SADC_OFF_RESULT     12'h004
`define SADC_OFF_PORTA      12'h008
`define SADC_OFF_PORTA_DIR  12'h00c
`define SADC_OFF_PORTA_OUT  12'h010
`define SADC_BIT_DONE       7
`define SADC_BIT_RC         6
`define SADC_BIT_POWER      5
`define SADC_CH_LSB         0
`define SADC_CH_W           3
`define SADC_CTRL_RESET     8'h00
`define SADC_RESULT_RESET   8'h00
`define SADC_CH_PA4         3'h0
`define SADC_CH_PA5         3'h1
`define SADC_CH_HIGH_REFERENCE       3'h4
`define SADC_CH_VMID        3'h5
`define SADC_CH_VREFL       3'h6
`define SADC_CONV_CYCLES    6'h20
`define SADC_CODE_FULL      8'hff
`define SADC_CODE_ZERO      8'h00
`define SADC_CODE_MID       8'h80
`endif

//--- core/sadc_sar.v
// successive approximation engine: one sample then eight comparison steps over 32 converter clock ticks
`include "sadc_map.vh"
module sadc_sar (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       start,
    input  wire       abort,
    input  wire       tick,
    input  wire [7:0] sample_in,
    output reg  [7:0] result_q,
    output reg        done_q
);
    reg [5:0] cnt_q;
    reg       busy_q;
    reg [7:0] held_q;
    reg [7:0] trial_q;
    reg [3:0] bit_q;
    wire [7:0] probe = trial_q | (8'h80 >> bit_q[2:0]);

    // -------------------------------------------------------------
    // sequencing
    // -------------------------------------------------------------
    // counter advances only on converter clock ticks; bit steps at every fourth tick
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= 6'h00;
            busy_q   <= 1'b0;
            held_q   <= 8'h00;
            trial_q  <= 8'h00;
            bit_q    <= 4'h0;
            result_q <= `SADC_RESULT_RESET;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                busy_q <= 1'b0;
                cnt_q  <= 6'h00;
            end else if (start) begin
                busy_q  <= 1'b1;
                cnt_q   <= 6'h00;
                held_q  <= sample_in;
                trial_q <= 8'h00;
                bit_q   <= 4'h0;
            end else if (busy_q && tick) begin
                if (cnt_q[1:0] == 2'h3 && bit_q < 4'h8) begin
                    // compare held input against dac trial, keep bit when not above
                    if (probe <= held_q) trial_q <= probe;
                    bit_q <= bit_q + 4'h1;
                end
                if (cnt_q == `SADC_CONV_CYCLES - 6'h01) begin
                    // restart on the next sample; unread results are simply overwritten
                    // the last trial bit is decided on this same tick, so fold it in here
                    result_q <= (bit_q < 4'h8 && probe <= held_q) ? probe : trial_q;
                    done_q   <= 1'b1;
                    cnt_q    <= 6'h00;
                    held_q   <= sample_in;
                    trial_q  <= 8'h00;
                    bit_q    <= 4'h0;
                end else begin
                    cnt_q <= cnt_q + 6'h01;
                end
            end
        end
    end
endmodule

//--- core/sadc_rcosc.v
// digital model of the internal rc oscillator: a free divider gated by its enable
module sadc_rcosc #(
    parameter [3:0] DIV = 4'h3
) (
    input  wire clk,
    input  wire rst_n,
    input  wire enable,
    output reg  tick_q
);
    reg [3:0] div_q;

    // -------------------------------------------------------------
    // divider
    // -------------------------------------------------------------
    // held cleared while disabled so the oscillator is truly off
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (!enable) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (div_q == DIV) begin
            div_q  <= 4'h0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 4'h1;
            tick_q <= 1'b0;
        end
    end
endmodule

//--- core/sadc_top.v
// converter sequencer top: apb registers, channel mux, port pin override, wait and stop
`include "sadc_map.vh"
module sadc_top #(
    parameter [3:0] RC_DIV = 4'h3
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [7:0]  ain_pa4,
    input  wire [7:0]  ain_pa5,
    input  wire [7:0]  ain_test,
    input  wire        ain_pa4_over,
    input  wire        ain_pa5_over,
    input  wire [7:0]  port_a_pins,
    input  wire        wait_mode,
    input  wire        stop_mode,
    output reg         power_on_q,
    output reg         rc_on_q
);
    reg  [7:0] ctrl_q;
    reg        done_q;
    reg  [7:0] dir_q;
    reg  [7:0] out_q;
    reg        start_q;
    reg        stop_d1_q;
    reg  [7:0] sample;
    reg  [7:0] porta_rd;
    reg  [31:0] rdata;
    reg        addr_ok;

    wire       power   = ctrl_q[`SADC_BIT_POWER];
    wire       rc_sel  = ctrl_q[`SADC_BIT_RC];
    wire [2:0] channel = ctrl_q[`SADC_CH_LSB +: `SADC_CH_W];
    wire       setup   = psel && !penable;
    wire       access  = psel && penable;
    wire       wr_ctrl = access && pwrite && (paddr == `SADC_OFF_CTRL);
    wire       rd_res  = access && !pwrite && (paddr == `SADC_OFF_RESULT);
    wire       rc_tick;
    wire [7:0] sar_res;
    wire       sar_done;
    wire       active  = power && !stop_mode;
    wire       tick    = rc_sel ? rc_tick : 1'b1;

    // -------------------------------------------------------------
    // analog selection
    // -------------------------------------------------------------
    // saturation of over-range inputs happens here so the engine never sees overflow
    always @* begin
        case (channel)
            `SADC_CH_PA4:   sample = ain_pa4_over ? `SADC_CODE_FULL : ain_pa4;
            `SADC_CH_PA5:   sample = ain_pa5_over ? `SADC_CODE_FULL : ain_pa5;
            `SADC_CH_HIGH_REFERENCE: sample = `SADC_CODE_FULL;
            `SADC_CH_VMID:  sample = `SADC_CODE_MID;
            `SADC_CH_VREFL: sample = `SADC_CODE_ZERO;
            3'h7:           sample = ain_test;
            // reserved codes give an undefined result; zero is as good as any
            default:        sample = `SADC_CODE_ZERO;
        endcase
    end

    // -------------------------------------------------------------
    // port a read path
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pa
            wire analog = power && ((gi == 4 && channel == `SADC_CH_PA4) ||
                                    (gi == 5 && channel == `SADC_CH_PA5));
            always @* begin
                if (dir_q[gi])
                    porta_rd[gi] = out_q[gi];
                else
                    porta_rd[gi] = analog ? 1'b0 : port_a_pins[gi];
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // engines
    // -------------------------------------------------------------
    sadc_rcosc #(
        .DIV    (RC_DIV)
    ) u_rc (
        .clk    (pclk),
        .rst_n  (presetn),
        .enable (rc_sel && !stop_mode),
        .tick_q (rc_tick)
    );

    sadc_sar u_sar (
        .clk       (pclk),
        .rst_n     (presetn),
        .start     (start_q && active),
        .abort     (!active),
        .tick      (tick),
        .sample_in (sample),
        .result_q  (sar_res),
        .done_q    (sar_done)
    );

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    // wait mode is deliberately not gated anywhere: the converter keeps going
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `SADC_CTRL_RESET;
            done_q    <= 1'b0;
            dir_q     <= 8'h00;
            out_q     <= 8'h00;
            start_q   <= 1'b0;
            stop_d1_q <= 1'b0;
        end else begin
            stop_d1_q <= stop_mode;
            // restart after leaving stop so a powered converter resumes
            start_q <= (wr_ctrl && pwrite) || (stop_d1_q && !stop_mode);
            if (wr_ctrl) begin
                ctrl_q <= {1'b0, pwdata[6:5], 2'b00, pwdata[2:0]};
            end
            if (access && pwrite && paddr == `SADC_OFF_PORTA_DIR) dir_q <= pwdata[7:0];
            if (access && pwrite && paddr == `SADC_OFF_PORTA_OUT) out_q <= pwdata[7:0];
            // a finishing conversion wins over a read clear; control writes and power off always clear
            if (!power || wr_ctrl || start_q)
                done_q <= 1'b0;
            else if (sar_done)
                done_q <= 1'b1;
            else if (rd_res)
                done_q <= 1'b0;
        end
    end

    // -------------------------------------------------------------
    // apb read mux
    // -------------------------------------------------------------
    always @* begin
        addr_ok = 1'b1;
        rdata   = 32'h0000_0000;
        case (paddr)
            `SADC_OFF_CTRL:      rdata = {24'h000000, done_q, rc_sel, power, 2'b00,
                                          channel};
            `SADC_OFF_RESULT:    rdata = {24'h000000, sar_res};
            `SADC_OFF_PORTA:     rdata = {24'h000000, porta_rd};
            `SADC_OFF_PORTA_DIR: rdata = {24'h000000, dir_q};
            `SADC_OFF_PORTA_OUT: rdata = {24'h000000, out_q};
            default:             addr_ok = 1'b0;
        endcase
    end

    // -------------------------------------------------------------
    // apb answer: no wait state, data registered at setup
    // -------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            power_on_q <= 1'b0;
            rc_on_q    <= 1'b0;
        end else begin
            power_on_q <= active;
            rc_on_q    <= rc_sel && !stop_mode;
            pready     <= setup;
            if (setup) begin
                prdata  <= pwrite ? 32'h0000_0000 : rdata;
                pslverr <= !addr_ok;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule

//--- sim/sadc_monitor.sv
// port checker of the converter sequencer
module sadc_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        stop_mode,
    input wire logic        power_on_q,
    input wire logic        rc_on_q
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------
    // helpers
    // --------
    logic [7:0] since_q;
    wire ctl_wr = pready && psel && pwrite && paddr == 12'h000;
    wire ctl_rd = pready && psel && !pwrite && paddr == 12'h000;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last control write; saturates so it never wraps back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            since_q <= 8'hff;
        else if (ctl_wr)
            since_q <= 8'h00;
        else if (since_q != 8'hff)
            since_q <= since_q + 8'h01;
    end
    // --------
    // checks
    // --------
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_error: assert property (psel && !penable && paddr > 12'h010
        |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    a_spare_bits_zero: assert property (ctl_rd |-> prdata[4:3] == 2'h0)
        else $error("spare control bits not zero");
    a_done_write_clear: assert property (ctl_rd && since_q < 8'h1e |-> !prdata[7])
        else $error("done set too soon after control write");
    a_stop_halts: assert property (stop_mode |=> !power_on_q)
        else $error("converter running in stop");
    a_power_follows: assert property (ctl_wr && pwdata[5] && !stop_mode
        |-> ##[1:2] (power_on_q || stop_mode)) else $error("power did not follow");
    a_rc_off: assert property (ctl_wr && !pwdata[6] |-> ##[1:2] !rc_on_q)
        else $error("rc oscillator left running");
    c_rc_write: cover property (ctl_wr && pwdata[6]);
    c_done_seen: cover property (ctl_rd && prdata[7]);
    c_stop_powered: cover property (stop_mode && power_on_q);
endmodule
bind sadc_top sadc_monitor i_sadc_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_mode, .power_on_q, .rc_on_q);

//--- sim/sadc_analog.sv
// analog side model: channel levels, over-range and raw port pins
module sadc_analog (
    input  wire logic       pclk,
    input  wire logic [7:0] lvl_a,
    input  wire logic [7:0] lvl_b,
    input  wire logic [1:0] ovr,
    input  wire logic [7:0] pins,
    output logic      [7:0] ain_pa4 = 8'h00,
    output logic      [7:0] ain_pa5 = 8'h00,
    output logic      [7:0] ain_test = 8'h00,
    output logic            ain_pa4_over = 1'b0,
    output logic            ain_pa5_over = 1'b0,
    output logic      [7:0] port_a_pins = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // --------
    // levels
    // --------
    // levels settle on the clock; above reference the input clips at full scale
    always_ff @(posedge pclk) begin
        ain_pa4 <= ovr[0] ? 8'hff : lvl_a;
        ain_pa5 <= ovr[1] ? 8'hff : lvl_b;
        ain_pa4_over <= ovr[0];
        ain_pa5_over <= ovr[1];
        ain_test <= 8'h3c; // arbitrary test level
        port_a_pins <= pins;
    end
endmodule

//--- sim/tb_sar_adc_sequencer.sv
// self-checking bench of the converter sequencer
module tb_sar_adc_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    // --------
    // signals
    // --------
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        wait_mode = 1'b0, stop_mode = 1'b0, pready, pslverr, power_on_q, rc_on_q;
    logic        ain_pa4_over, ain_pa5_over;
    logic [1:0]  ovr = 2'h0;
    logic [7:0]  lvl_a = 8'h00, lvl_b = 8'h00, pins = 8'h00, ain_pa4, ain_pa5, ain_test;
    logic [7:0]  port_a_pins, ev[5];
    logic [7:0]  pw[4] = '{8'h20, 8'h21, 8'h24, 8'h00};
    logic [7:0]  pe[4] = '{8'hef, 8'hdf, 8'hff, 8'hff};
    logic [2:0]  chs[5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata, st = 32'h21, x;
    logic [63:0] e, exp_q[$];
    int          n_fail = 0, tests_run = 0, cyc = 0, tdone, t1, i;
    sadc_analog i_sadc_analog (.pclk, .lvl_a, .lvl_b, .ovr, .pins, .ain_pa4, .ain_pa5,
        .ain_test, .ain_pa4_over, .ain_pa5_over, .port_a_pins);
    sadc_top #(.RC_DIV(4'h3)) i_sadc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ain_pa4, .ain_pa5, .ain_test, .ain_pa4_over,
        .ain_pa5_over, .port_a_pins, .wait_mode, .stop_mode, .power_on_q, .rc_on_q);
    // --------
    // helpers
    // --------
    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    function automatic logic [31:0] rnd();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one bus transfer; request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        exp_q.push_back({m, v});
        apb(1'b0, a, 32'h0);
    endtask
    // polling, not cycle counting, since the rc clock is not tied to the bus
    task automatic wait_done();
        rdata = 32'h0;
        for (int k = 0; k < 300 && rdata[7] !== 1'b1; k++)
            rd(12'h000, 32'h0, 32'h0);
        tdone = cyc;
    endtask
    // read results against the oldest note; a zero mask marks a poll
    always @(posedge pclk)
        if (pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[63:32] != 32'h0)
                chk("prdata", prdata & e[63:32], e[31:0]);
        end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        stop_test();
    end
    // --------
    // tests
    // --------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h000, 32'hffffffff, 32'h0);
        rd(12'h004, 32'hffffffff, 32'h0);
        rd(12'h014, 32'hffffffff, 32'h0);
        $display("reset test done");
        for (i = 0; i < 5; i++) begin
            x = rnd();
            lvl_a <= x[7:0];
            lvl_b <= x[15:8];
            ev = '{x[7:0], x[15:8], 8'hff, 8'h80, 8'h00};
            apb(1'b1, 12'h000, {29'h4, chs[i]} | 32'h18);
            rd(12'h000, 32'hff, {29'h4, chs[i]});
            wait_done();
            rd(12'h004, 32'hff, {24'h0, ev[i]});
            rd(12'h000, 32'h80, 32'h0);
        end
        $display("channel test done");
        apb(1'b1, 12'h000, 32'h20);
        wait_done();
        t1 = tdone;
        rd(12'h004, 32'hff, {24'h0, ev[0]});
        lvl_a <= 8'h5a;
        wait_done();
        chk("period", 32'(tdone - t1 inside {[29:35]}), 32'h1);
        rd(12'h004, 32'hff, {24'h0, ev[0]});
        wait_done();
        rd(12'h004, 32'hff, 32'h5a);
        ovr <= 2'h1;
        apb(1'b1, 12'h000, 32'h20);
        wait_done();
        rd(12'h004, 32'hff, 32'hff);
        ovr <= 2'h0;
        $display("repeat test done");
        apb(1'b1, 12'h000, 32'h64);
        t1 = cyc;
        wait_done();
        chk("rc time", 32'(tdone - t1 >= 128), 32'h1);
        rd(12'h004, 32'hff, 32'hff);
        apb(1'b1, 12'h000, 32'h24);
        $display("rc test done");
        pins <= 8'hff;
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h000, {24'h0, pw[i]});
            rd(12'h008, 32'hff, {24'h0, pe[i]});
        end
        pins <= 8'h00;
        apb(1'b1, 12'h00c, 32'h10);
        apb(1'b1, 12'h010, 32'h10);
        apb(1'b1, 12'h000, 32'h20);
        rd(12'h008, 32'hff, 32'h10);
        $display("port test done");
        wait_mode <= 1'b1;
        apb(1'b1, 12'h000, 32'h24);
        wait_done();
        rd(12'h004, 32'hff, 32'hff);
        apb(1'b1, 12'h000, 32'h24);
        repeat (10) @(posedge pclk);
        stop_mode <= 1'b1;
        repeat (80) @(posedge pclk);
        rd(12'h000, 32'h80, 32'h0);
        stop_mode <= 1'b0;
        wait_done();
        rd(12'h004, 32'hff, 32'hff);
        $display("wait and stop test done");
        stop_test();
    end
endmodule
